// ---- src/dch_host.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] Raise event; drive then fetches operation byte
// [RQ2] Drive paces transfers with address and strobe
// [RQ3] Acknowledge paces each byte, answering each strobe
// [RQ4] Drive fetches parameter bytes per operation byte
// [RQ5] Several operations share one operation byte
// [RQ6] Always accept unsolicited status transfers
// [RQ7] Drive sets address 400 ns before strobe
// [RQ8] Answer each strobe within 500 us
// [RQ9] Data valid within 1 us of acknowledge
// [RQ10] Drive releases bus within 200 ns
// [RQ11] Drive bus only after strobe, inbound direction
// [RQ12] Drive captures byte, then drops strobe
// [RQ13] Seek: op byte, cylinder high, cylinder low
// [RQ14] Take and acknowledge seek-complete status byte
// [RQ15] Interrupt request independent of unit selection
// [RQ16] Drive raises interrupt request on status change
// [RQ17] Drive defers new event until prior done
// [RQ18] Drive blocks writes from event leading edge
// [RQ19] Write during block raises drive fault
// [RQ20] Never raise event during data operation
// [RQ21] Selected drive sends status changes unprompted
// [RQ22] Hold event until strobe with address 111
// [RQ23] Drop event after acknowledging operation byte
// [RQ24] Direction high means toward drive
// [RQ25] Eight-bit shared three-state bus
// [RQ26] Three address lines give byte meaning
// [RQ27] Strobe held until acknowledge; no early restart
`include "dch_map.svh"

module dch_host (
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  // AXI4-Lite slave
  input wire logic [5:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [5:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // Drive link
  output logic O_EVENT,
  input wire logic I_BUS_READY,
  input wire dch_pkg::dch_code_t I_ADDR,
  input wire logic I_TO_DRIVE,
  output logic O_ACK,
  input wire dch_pkg::dch_byte_t I_BUS_DATA,
  output dch_pkg::dch_byte_t O_BUS_DATA,
  output logic O_BUS_OE,
  input wire logic I_INT_REQ,
  input wire logic I_DATA_OP_BUSY
);
  import dch_pkg::*;

  // ==========================================================
  // Decode helpers
  function automatic logic is_tab(input logic [5:0] a);
    is_tab = (a[5] == 1'b1) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic is_known(input logic [5:0] a);
    is_known = is_tab(a) || (a == `DCH_OFF_CTRL) || (a == `DCH_OFF_STAT) ||
      (a == `DCH_OFF_RXDATA);
  endfunction

  // ==========================================================
  // State
  dch_hs_e hs_r;
  dch_hs_e hs_nxt;
  dch_byte_t tab_r [8];
  dch_byte_t rx_data_r;
  dch_code_t rx_addr_r;
  logic rx_new_r;
  logic irq_r;
  logic event_r;
  logic op_xfer_r;
  logic ack_r;
  logic oe_r;
  dch_byte_t bus_out_r;
  logic aw_got_r;
  logic w_got_r;
  logic [5:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic awready_r;
  logic wready_r;
  logic arready_r;

  // ==========================================================
  // Bus decode
  wire aw_take = I_AWVALID && !aw_got_r && !bvalid_r;
  wire w_take = I_WVALID && !w_got_r && !bvalid_r;
  wire wr_fire = aw_got_r && w_got_r && !bvalid_r;
  wire ar_take = I_ARVALID && !rvalid_r;
  wire aw_got_nxt = wr_fire ? 1'b0 : (aw_take || aw_got_r);
  wire w_got_nxt = wr_fire ? 1'b0 : (w_take || w_got_r);
  wire bvalid_nxt = wr_fire || (bvalid_r && !I_BREADY);
  wire rvalid_nxt = ar_take || (rvalid_r && !I_RREADY);
  wire wr_ctrl = wr_fire && (aw_addr_r == `DCH_OFF_CTRL) && w_strb_r[0];
  wire wr_stat = wr_fire && (aw_addr_r == `DCH_OFF_STAT) && w_strb_r[0];
  wire wr_tab = wr_fire && is_tab(aw_addr_r) && w_strb_r[0];
  wire [2:0] wr_idx = aw_addr_r[4:2];
  wire go = wr_ctrl && w_data_r[`DCH_CTRL_GO];
  wire clr_rx = wr_stat && w_data_r[`DCH_STAT_RXNEW];
  wire hs_busy = (hs_r != HS_IDLE);
  wire [31:0] stat_word = {21'h000000, rx_addr_r, 4'h0, hs_busy, rx_new_r, irq_r, event_r};
  wire [31:0] rd_word =
    (I_ARADDR == `DCH_OFF_CTRL) ? {31'h00000000, event_r} :
    (I_ARADDR == `DCH_OFF_STAT) ? stat_word :
    (I_ARADDR == `DCH_OFF_RXDATA) ? {24'h000000, rx_data_r} :
    is_tab(I_ARADDR) ? {24'h000000, tab_r[I_ARADDR[4:2]]} : `DCH_WORD_RST;

  // ==========================================================
  // Link decode
  wire strobe_in = I_BUS_READY && I_TO_DRIVE;                 // [RQ24]
  wire strobe_out = I_BUS_READY && !I_TO_DRIVE;
  wire op_fetch = strobe_in && (I_ADDR == `DCH_OP_ADDR);      // [RQ22]
  wire start_ok = go && !event_r && !I_DATA_OP_BUSY;          // [RQ20]
  wire rx_capture = (hs_r == HS_IDLE) && strobe_out;          // [RQ6] [RQ14] [RQ21]
  wire op_done = (hs_r == HS_HOLD) && op_xfer_r;              // [RQ23]

  always_comb begin
    hs_nxt = hs_r;
    unique case (hs_r)
      HS_IDLE: begin
        if (strobe_in) begin
          hs_nxt = HS_LOAD;
        end else if (strobe_out) begin
          hs_nxt = HS_HOLD;
        end
      end
      HS_LOAD: hs_nxt = HS_HOLD;
      HS_HOLD: begin
        if (!I_BUS_READY) begin
          hs_nxt = HS_IDLE;                                   // [RQ27]
        end
      end
    endcase
  end

  // ==========================================================
  // Handshake
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      hs_r <= HS_IDLE;
      ack_r <= 1'b0;
      oe_r <= 1'b0;
      bus_out_r <= `DCH_BYTE_RST;
      op_xfer_r <= 1'b0;
    end else begin
      hs_r <= hs_nxt;
      if ((hs_r == HS_IDLE) && strobe_in) begin
        oe_r <= 1'b1;                                         // [RQ11] [RQ25]
        bus_out_r <= tab_r[I_ADDR];                           // [RQ4] [RQ5] [RQ13] [RQ26]
        op_xfer_r <= op_fetch;
      end
      if (hs_r == HS_LOAD) begin
        ack_r <= 1'b1;                                        // [RQ3] [RQ9]
      end
      if (rx_capture) begin
        ack_r <= 1'b1;                                        // [RQ3] [RQ8]
        op_xfer_r <= 1'b0;
      end
      if ((hs_r == HS_HOLD) && !I_BUS_READY) begin
        ack_r <= 1'b0;                                        // [RQ12]
        oe_r <= 1'b0;
      end
      if (op_done) begin
        op_xfer_r <= 1'b0;                                    // [RQ23]
      end
    end
  end

  // ==========================================================
  // Event and received status
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      event_r <= 1'b0;
      rx_data_r <= `DCH_BYTE_RST;
      rx_addr_r <= 3'h0;
      rx_new_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      irq_r <= I_INT_REQ;                                     // [RQ15] [RQ16]
      if (start_ok) begin
        event_r <= 1'b1;                                      // [RQ1]
      end else if (op_done) begin
        event_r <= 1'b0;                                      // [RQ23]
      end
      if (rx_capture) begin
        rx_data_r <= I_BUS_DATA;                              // [RQ14]
        rx_addr_r <= I_ADDR;
      end
      if (rx_capture) begin
        rx_new_r <= 1'b1;
      end else if (clr_rx) begin
        rx_new_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Byte table, one per address code
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      for (int i = 0; i < 8; i++) begin
        tab_r[i] <= `DCH_BYTE_RST;
      end
    end else if (wr_tab) begin
      tab_r[wr_idx] <= w_data_r[7:0];
    end
  end

  // ==========================================================
  // AXI4-Lite write path
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 6'h00;
      w_data_r <= `DCH_WORD_RST;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `DCH_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= I_AWADDR;
      end
      if (w_take) begin
        w_got_r <= 1'b1;
        w_data_r <= I_WDATA;
        w_strb_r <= I_WSTRB;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= is_known(aw_addr_r) ? `DCH_RESP_OKAY : `DCH_RESP_SLVERR;
      end else if (bvalid_r && I_BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rvalid_r <= 1'b0;
      rdata_r <= `DCH_WORD_RST;
      rresp_r <= `DCH_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= is_known(I_ARADDR) ? `DCH_RESP_OKAY : `DCH_RESP_SLVERR;
    end else if (rvalid_r && I_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // Registered ready outputs
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      arready_r <= 1'b1;
    end else begin
      awready_r <= !aw_got_nxt && !bvalid_nxt;
      wready_r <= !w_got_nxt && !bvalid_nxt;
      arready_r <= !rvalid_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign O_AWREADY = awready_r;
  assign O_WREADY = wready_r;
  assign O_BVALID = bvalid_r;
  assign O_BRESP = bresp_r;
  assign O_ARREADY = arready_r;
  assign O_RVALID = rvalid_r;
  assign O_RDATA = rdata_r;
  assign O_RRESP = rresp_r;
  assign O_EVENT = event_r;
  assign O_ACK = ack_r;
  assign O_BUS_DATA = bus_out_r;
  assign O_BUS_OE = oe_r;

endmodule // dch_host

// ---- src/dch_map.svh ----
`ifndef DCH_MAP_SVH
`define DCH_MAP_SVH

// ==========================================================
// Register offsets
`define DCH_OFF_CTRL 6'h00
`define DCH_OFF_STAT 6'h04
`define DCH_OFF_RXDATA 6'h08
`define DCH_OFF_TAB 6'h20

// ==========================================================
// Field positions
`define DCH_CTRL_GO 0
`define DCH_STAT_EVENT 0
`define DCH_STAT_IRQ 1
`define DCH_STAT_RXNEW 2
`define DCH_STAT_BUSY 3
`define DCH_STAT_ADDR_LO 8
`define DCH_STAT_ADDR_HI 10

// ==========================================================
// Codes and reset values
`define DCH_OP_ADDR 3'h7
`define DCH_RESP_OKAY 2'h0
`define DCH_RESP_SLVERR 2'h2
`define DCH_BYTE_RST 8'h00
`define DCH_WORD_RST 32'h00000000

`endif

// ---- src/dch_pkg.sv ----
package dch_pkg;
  typedef logic [7:0] dch_byte_t;
  typedef logic [2:0] dch_code_t;
  typedef enum logic [1:0] {HS_IDLE, HS_LOAD, HS_HOLD} dch_hs_e;
endpackage

// ---- sim/dch_host_assertions.sv ----
`timescale 1ns/1ps
// ========
// Link checks
module dch_host_assertions (
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire logic I_BUS_READY,
  input wire dch_pkg::dch_code_t I_ADDR,
  input wire logic I_TO_DRIVE,
  input wire logic I_DATA_OP_BUSY,
  input wire logic O_EVENT,
  input wire logic O_ACK,
  input wire logic O_BUS_OE
);
  import dch_pkg::*;
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RSTN);
  wire logic op_x = O_ACK && I_TO_DRIVE && I_ADDR == 3'h7;
  property p_ack_out;
    $rose(I_BUS_READY) && !I_TO_DRIVE && !O_ACK |=> O_ACK;
  endproperty
  a_ack_out: assert property (p_ack_out) else $error("no outbound ack");
  property p_ack_in;
    $rose(I_BUS_READY) && I_TO_DRIVE && !O_ACK |=> O_BUS_OE && !O_ACK ##1 O_ACK;
  endproperty
  a_ack_in: assert property (p_ack_in) else $error("bad inbound ack");
  property p_oe;
    O_BUS_OE |-> $past(I_BUS_READY) && $past(I_TO_DRIVE);
  endproperty
  a_oe: assert property (p_oe) else $error("bus driven early");
  property p_hold;
    O_ACK && I_BUS_READY |=> O_ACK;
  endproperty
  a_hold: assert property (p_hold) else $error("ack dropped early");
  property p_drop;
    O_ACK && !I_BUS_READY |=> !O_ACK && !O_BUS_OE;
  endproperty
  a_drop: assert property (p_drop) else $error("ack not released");
  property p_ev_drop;
    $rose(O_ACK) && I_TO_DRIVE && I_ADDR == 3'h7 |=> !O_EVENT;
  endproperty
  a_ev_drop: assert property (p_ev_drop) else $error("event kept");
  property p_ev_hold;
    O_EVENT && !op_x |=> O_EVENT;
  endproperty
  a_ev_hold: assert property (p_ev_hold) else $error("event lost");
  property p_busy;
    $rose(O_EVENT) |-> !$past(I_DATA_OP_BUSY);
  endproperty
  a_busy: assert property (p_busy) else $error("event in data op");
  c_op: cover property (op_x);
  c_out: cover property (O_ACK && !I_TO_DRIVE);
  c_ev: cover property ($rose(O_EVENT));
endmodule // dch_host_assertions

bind dch_host dch_host_assertions dch_host_assertions_inst (.I_REF_CLK(I_REF_CLK),
  .I_RSTN(I_RSTN), .I_BUS_READY(I_BUS_READY), .I_ADDR(I_ADDR), .I_TO_DRIVE(I_TO_DRIVE),
  .I_DATA_OP_BUSY(I_DATA_OP_BUSY), .O_EVENT(O_EVENT), .O_ACK(O_ACK), .O_BUS_OE(O_BUS_OE));

// ---- sim/dch_drive_model.sv ----
`timescale 1ns/1ps
// ========
// Drive model
module dch_drive_model (
  input wire logic i_clk,
  input wire logic i_event,
  input wire logic i_ack,
  input wire logic i_kick,
  input wire logic i_wr_try,
  input wire dch_pkg::dch_byte_t i_bus,
  input wire dch_pkg::dch_byte_t i_stat,
  output logic o_ready,
  output dch_pkg::dch_code_t o_addr,
  output logic o_to_drive,
  output dch_pkg::dch_byte_t o_data,
  output logic o_oe,
  output logic o_int_req,
  output dch_pkg::dch_byte_t o_op,
  output logic [15:0] o_cyl,
  output logic [7:0] o_done,
  output logic [7:0] o_faults
);
  import dch_pkg::*;
  dch_byte_t b;
  dch_byte_t opb;
  logic [7:0] fault_cnt = 8'h00;
  assign o_faults = fault_cnt;
  always @(posedge i_clk) begin
    if (i_wr_try && i_event) begin
      fault_cnt <= fault_cnt + 8'h01;
    end
  end
  task automatic xfer(input dch_code_t a, input logic dir, inout dch_byte_t d);
    o_addr <= a;
    o_to_drive <= dir;
    o_oe <= !dir;
    o_data <= d;
    repeat (4) @(posedge i_clk);
    o_ready <= 1'b1;
    do @(posedge i_clk); while (!i_ack);
    if (dir) d = i_bus;
    o_ready <= 1'b0;
    do @(posedge i_clk); while (i_ack);
    o_oe <= 1'b0;
    o_data <= ~d;
    @(posedge i_clk);
  endtask
  initial begin
    {o_ready, o_addr, o_to_drive, o_oe, o_int_req, o_op, o_cyl, o_done} = '0;
    o_data = 8'h5a;
    forever begin
      @(posedge i_clk);
      if (i_event) begin
        xfer(3'h7, 1'b1, b);
        opb = b;
        o_op <= b;
        if (opb[0]) begin
          xfer(3'h1, 1'b1, b);
          o_cyl[15:8] <= b;
          xfer(3'h2, 1'b1, b);
          o_cyl[7:0] <= b;
        end
        b = i_stat;
        xfer(3'h0, 1'b0, b);
        o_int_req <= opb[7];
        o_done <= o_done + 8'h01;
      end else if (i_kick) begin
        b = i_stat;
        xfer(3'h0, 1'b0, b);
        o_done <= o_done + 8'h01;
      end
    end
  end
endmodule // dch_drive_model

// ---- sim/tb.sv ----
`timescale 1ns/1ps
// ========
// Bench
module tb;
  import dch_pkg::*;
  logic clk = 0, rstn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, kick = 0, busy = 0;
  logic wrt = 0;
  logic [5:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rv, rdata;
  logic awrdy, wrdy, bvld, arrdy, rvld, ev, ack, hoe, mrdy, mdir, moe, mint;
  logic [1:0] bresp, rresp;
  dch_byte_t hdata, mdata, bus, op, stat = 8'h10;
  dch_code_t maddr;
  logic [15:0] cyl;
  logic [7:0] done;
  logic [7:0] faults;
  int err_count = 0, n_compared = 0;
  assign bus = hoe ? hdata : moe ? mdata : 8'hff;
  always #50 clk = ~clk;
  dch_host dch_host_inst (.I_REF_CLK(clk), .I_RSTN(rstn), .I_AWADDR(awa), .I_AWVALID(awv),
    .O_AWREADY(awrdy), .I_WDATA(wd), .I_WSTRB(4'h1), .I_WVALID(wv), .O_WREADY(wrdy),
    .O_BRESP(bresp), .O_BVALID(bvld), .I_BREADY(bry), .I_ARADDR(ara), .I_ARVALID(arv),
    .O_ARREADY(arrdy), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvld), .I_RREADY(rry),
    .O_EVENT(ev), .I_BUS_READY(mrdy), .I_ADDR(maddr), .I_TO_DRIVE(mdir), .O_ACK(ack),
    .I_BUS_DATA(bus), .O_BUS_DATA(hdata), .O_BUS_OE(hoe), .I_INT_REQ(mint),
    .I_DATA_OP_BUSY(busy));
  dch_drive_model dch_drive_model_inst (.i_clk(clk), .i_event(ev), .i_ack(ack), .i_kick(kick),
    .i_wr_try(wrt),
    .i_bus(bus), .i_stat(stat), .o_ready(mrdy), .o_addr(maddr), .o_to_drive(mdir),
    .o_data(mdata), .o_oe(moe), .o_int_req(mint), .o_op(op), .o_cyl(cyl), .o_done(done),
    .o_faults(faults));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bvld);
    bry <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arrdy) arv <= 1'b0;
    end while (!rvld);
    rv = rdata;
    rry <= 1'b0;
  endtask
  task automatic t_seek;
    rd(6'h10);
    chk("rresp", 32'h2, {30'h0, rresp});
    wr(6'h3c, 32'h81);
    wr(6'h24, 32'h12);
    wr(6'h28, 32'h34);
    wr(6'h00, 32'h1);
    wrt <= 1'b1;
    @(posedge clk);
    wrt <= 1'b0;
    while (done != 8'h01) @(posedge clk);
    chk("op", 32'h81, {24'h0, op});
    chk("cyl", 32'h1234, {16'h0, cyl});
    chk("faults", 32'h1, {24'h0, faults});
    rd(6'h08);
    chk("rx", 32'h10, rv);
    rd(6'h04);
    chk("stat", 32'h6, {26'h0, rv[10:8], rv[2:0]});
    $display("test seek done");
  endtask
  task automatic t_plain;
    stat = 8'h20;
    wr(6'h3c, 32'h02);
    wr(6'h00, 32'h1);
    while (done != 8'h02) @(posedge clk);
    chk("op", 32'h2, {24'h0, op});
    rd(6'h08);
    chk("rx", 32'h20, rv);
    chk("irq", 32'h0, {31'h0, mint});
    rd(6'h04);
    chk("irq_stat", 32'h0, {31'h0, rv[1]});
    $display("test plain done");
  endtask
  task automatic t_kick;
    stat = 8'h33;
    @(posedge clk);
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    while (done != 8'h03) @(posedge clk);
    rd(6'h08);
    chk("rx", 32'h33, rv);
    busy <= 1'b1;
    wr(6'h00, 32'h1);
    rd(6'h00);
    chk("event", 32'h0, {31'h0, rv[0]});
    busy <= 1'b0;
    wrt <= 1'b1;
    @(posedge clk);
    wrt <= 1'b0;
    @(posedge clk);
    chk("faults", 32'h1, {24'h0, faults});
    $display("test kick done");
  endtask
  task automatic close_out;
    $display("Counts: compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out;
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_seek;
    t_plain;
    t_kick;
    close_out;
  end
endmodule // tb
